// ===== rtl/bcbr_pkg.sv
// constants and types for the bit-clear and flag-branch executor
// assumes a single core clock; the core's fetch stage supplies instruction
// words and their addresses one at a time
// Overview of operation
// - Bit-clear is opcode nibble 1001 with bit index, bank flag and address; it zeroes one bit and keeps the rest.
// - With bank flag zero the address resolves in the access bank, ignoring the bank select register.
// - With bank flag one the address resolves in the bank named by the bank select register.
// - Branch-if-negative, upper byte 1110 0110, loads the target only when the negative flag is one.
// - Branch-if-not-carry is recognised by upper byte 1110 0011, with a signed 8-bit offset in the low byte.
// - Branch-if-not-carry redirects only when carry is zero, otherwise execution runs on sequentially.
// - The offset is two's complement from -128 to 127 and is doubled before being added.
// - A taken branch sets the program counter to the branch address plus two plus twice the offset.
// - A branch is one word, one cycle if not taken, two if taken with an idle second cycle.
package bcbr_pkg;
   localparam int PC_WIDTH = 21;
   localparam int ADDR_WIDTH = 12;
   localparam logic [3:0] BIT_CLEAR_NIBBLE = 4'h9;
   localparam logic [7:0] BRANCH_NEG_BYTE = 8'hE6;
   localparam logic [7:0] BRANCH_NO_CARRY_BYTE = 8'hE3;
   // access bank: low half in bank 0, high half in bank 15
   localparam logic [7:0] ACCESS_SPLIT = 8'h80;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
   localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
   localparam logic [PC_WIDTH-1:0] PC_STEP = 21'h000002;
   localparam logic [PC_WIDTH-1:0] PC_RESET = 21'h000000;

   typedef enum logic [1:0] {
      EXEC = 2'b00,
      IDLE_AFTER_JUMP = 2'b01
   } exec_state_type;
endpackage

// ===== rtl/bit_clear_and_flag_branch_exec.sv
// executes bit-clear, branch-if-negative and branch-if-not-carry
// assumes fetch presents one instruction with its address and holds it
// while ready is low; status flags come from the same clock domain
`timescale 1ns/1ps
module bit_clear_and_flag_branch_exec
   import bcbr_pkg::*;
#(
   parameter int PCW = bcbr_pkg::PC_WIDTH,
   parameter int AW = bcbr_pkg::ADDR_WIDTH
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // instruction from fetch
   input wire logic instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic [PCW-1:0] instr_addr,
   output logic instr_ready,
   // status and bank select
   input wire logic negative_flag,
   input wire logic carry_flag,
   input wire logic [3:0] bank_select_reg,
   // program counter redirect
   output logic pc_load,
   output logic [PCW-1:0] pc_target,
   output logic flush,
   // retire and decode results
   output logic done,
   output logic unknown_op,
   // observed data memory write
   output logic mem_wr_en,
   output logic [AW-1:0] mem_wr_addr,
   output logic [7:0] mem_wr_data
);
   import bcbr_pkg::*;

   exec_state_type state, next_state;

   // phase 0 captures decode, phase 1 finishes read-modify-write
   logic clr_pending;
   logic [AW-1:0] clr_addr;
   logic [2:0] clr_bit;
   logic [7:0] rd_data;

   // decoded fields of the offered word
   logic is_clear;
   logic is_bneg;
   logic is_bnc;
   logic bank_flag;
   logic [2:0] bit_index;
   logic [7:0] reg_offset;
   logic [7:0] branch_offset;
   // bank resolution
   logic [3:0] access_bank;
   logic [3:0] eff_bank;
   logic [AW-1:0] eff_addr;
   // branch conditions and handshake
   logic take_bneg;
   logic take_bnc;
   logic in_exec;
   logic accept;
   logic take;
   logic clear_now;
   logic branch_not_taken;
   logic retire_now;
   logic [7:0] clear_mask;

   // sign-extend and double the offset
   function automatic logic [PCW-1:0] offset_disp(
      input logic [7:0] off
   );
      offset_disp = {{(PCW-9){off[7]}}, off, 1'b0};
   endfunction

   function automatic logic [PCW-1:0] branch_target(
      input logic [PCW-1:0] here,
      input logic [7:0] off
   );
      branch_target = here + PC_STEP + offset_disp(off);
   endfunction

   // bank used when the bank flag is clear
   function automatic logic [3:0] access_bank_of(
      input logic [7:0] offset
   );
      if (offset >= ACCESS_SPLIT) begin
         access_bank_of = ACCESS_HIGH_BANK;
      end else begin
         access_bank_of = ACCESS_LOW_BANK;
      end
   endfunction

   // all ones except the addressed bit
   function automatic logic [7:0] hole_mask(
      input logic [2:0] idx
   );
      hole_mask = ~(8'h01 << idx);
   endfunction

   assign is_clear = instr_word[15:12] == BIT_CLEAR_NIBBLE;
   assign is_bneg = instr_word[15:8] == BRANCH_NEG_BYTE;
   assign is_bnc = instr_word[15:8] == BRANCH_NO_CARRY_BYTE;
   assign bank_flag = instr_word[8];
   assign bit_index = instr_word[11:9];
   assign reg_offset = instr_word[7:0];
   assign branch_offset = instr_word[7:0];
   assign access_bank = access_bank_of(reg_offset);
   assign eff_bank = bank_flag ? bank_select_reg : access_bank;
   assign eff_addr = {eff_bank, reg_offset};
   assign take_bneg = is_bneg && negative_flag;
   assign take_bnc = is_bnc && !carry_flag;
   assign in_exec = state == EXEC;
   // a bit-clear occupies the cycle after its decode for write-back
   assign accept = instr_valid && in_exec && !clr_pending;
   assign take = accept && (take_bneg || take_bnc);
   assign clear_now = accept && is_clear;
   assign branch_not_taken = accept && (is_bneg || is_bnc) && !take;
   // bit-clear retires with its write, a jump after its idle cycle
   assign retire_now = branch_not_taken || (state == IDLE_AFTER_JUMP)
      || clear_now;
   assign clear_mask = hole_mask(clr_bit);

   assign instr_ready = in_exec && !clr_pending;

   always_comb begin
      next_state = state;
      case (state)
         EXEC: begin
            if (take) begin
               next_state = IDLE_AFTER_JUMP;
            end
         end
         IDLE_AFTER_JUMP: begin
            next_state = EXEC;
         end
         default: begin
            next_state = EXEC;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state <= EXEC;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         clr_pending <= 1'b0;
      end else begin
         clr_pending <= clear_now;
      end
   end

   // bit-clear target held for the write-back cycle
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         clr_addr <= '0;
         clr_bit <= 3'h0;
      end else if (clear_now) begin
         clr_addr <= eff_addr;
         clr_bit <= bit_index;
      end
   end

   data_ram #(.AW(AW), .DW(8)) u_ram (
      .core_clk(core_clk),
      .rd_addr(eff_addr),
      .rd_data(rd_data),
      .wr_en(mem_wr_en),
      .wr_addr(mem_wr_addr),
      .wr_data(mem_wr_data)
   );

   // pc redirect pulses one cycle after the take
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pc_load <= 1'b0;
         flush <= 1'b0;
      end else begin
         pc_load <= take;
         flush <= take;
      end
   end

   // target holds until the next taken branch
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pc_target <= PC_RESET;
      end else if (take) begin
         pc_target <= branch_target(instr_addr, branch_offset);
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         done <= 1'b0;
      end else begin
         done <= retire_now;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         unknown_op <= 1'b0;
      end else begin
         unknown_op <= accept && !is_clear && !is_bneg && !is_bnc;
      end
   end

   // write-back: only the addressed bit changes, no flag output exists
   assign mem_wr_en = clr_pending;
   assign mem_wr_addr = clr_addr;
   assign mem_wr_data = rd_data & clear_mask;
endmodule

// ===== rtl/data_ram.sv
// small data memory, one read and one write port, registered read data
// assumes address and write enable are from the core clock domain
`timescale 1ns/1ps
module data_ram #(
   parameter int AW = 12,
   parameter int DW = 8
) (
   // clock
   input wire logic core_clk,
   // read port
   input wire logic [AW-1:0] rd_addr,
   output logic [DW-1:0] rd_data,
   // write port
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [DW-1:0] wr_data
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule

// ===== tb/bcbr_asserts.sv
// port checker for the bit-clear and flag-branch executor
// bound to every instance of the executor below
`timescale 1ns/1ps
module bcbr_asserts
   import bcbr_pkg::*;
(
   input wire logic core_clk, rst, instr_valid, instr_ready,
   input wire logic [15:0] instr_word,
   input wire logic [PC_WIDTH-1:0] instr_addr, pc_target,
   input wire logic negative_flag, carry_flag, pc_load, flush, done,
   input wire logic [3:0] bank_select_reg,
   input wire logic mem_wr_en,
   input wire logic [ADDR_WIDTH-1:0] mem_wr_addr,
   input wire logic [7:0] mem_wr_data
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   wire tk = instr_valid && instr_ready;
   wire [7:0] op = instr_word[15:8];
   wire neg = op == BRANCH_NEG_BYTE;
   wire nc = op == BRANCH_NO_CARRY_BYTE;
   wire br = tk && (neg && negative_flag || nc && !carry_flag);
   wire nb = tk && (neg && !negative_flag || nc && carry_flag);
   wire clr = tk && instr_word[15:12] == BIT_CLEAR_NIBBLE;
   logic [PC_WIDTH-1:0] t;
   logic [ADDR_WIDTH-1:0] wa;
   logic [2:0] bi;
   // expected target, address and bit of the word taken
   always_ff @(posedge core_clk) begin
      t <= instr_addr + PC_STEP + {{12{instr_word[7]}}, op[7:0] & 8'h00
         | instr_word[7:0], 1'b0};
      wa <= {instr_word[8] ? bank_select_reg : instr_word[7] ?
         ACCESS_HIGH_BANK : ACCESS_LOW_BANK, instr_word[7:0]};
      bi <= instr_word[11:9];
   end
   sequence jump_s;
      pc_load && flush ##1 done;
   endsequence
   a_jump_taken: assert property (br |=> jump_s) else $error("jump");
   a_jump_skip: assert property (nb |=> done && !pc_load) else $error("skip");
   a_jump_target: assert property (br |=> pc_target == t) else $error("tgt");
   a_idle_stall: assert property (br |=> !instr_ready) else $error("idle");
   a_clr_write: assert property (clr |=> mem_wr_en && done) else $error("wr");
   a_clr_addr: assert property (clr |=> mem_wr_addr == wa) else $error("adr");
   a_clr_bit: assert property (clr |=> !mem_wr_data[bi]) else $error("bit");
   a_no_spur: assert property (mem_wr_en |-> $past(clr)) else $error("spur");
endmodule
bind bit_clear_and_flag_branch_exec bcbr_asserts chk_u (.*);

// ===== tb/bit_clear_and_flag_branch_exec_tb_top.sv
// random bit-clear and branch words through the fetch model
// retire results checked in order against a queue of notes
`timescale 1ns/1ps
module bit_clear_and_flag_branch_exec_tb_top;
   import bcbr_pkg::*;
   logic core_clk = 1'b0, rst = 1'b1, tks = 1'b0;
   logic vld, rdy, pc_load, flush, done, unk, wen;
   logic [15:0] word;
   logic [20:0] addr, pc_target;
   logic [5:0] st;
   logic [11:0] wa;
   logic [7:0] wd;
   logic [31:0] q[$], seed = 32'h4eb1f3ab, obs;
   int error_cnt = 0, checks = 0;
   always #2.5 core_clk = ~core_clk;
   fetch_model fm (.clk(core_clk), .rdy(rdy), .vld(vld), .word(word),
      .addr(addr), .st(st));
   bit_clear_and_flag_branch_exec dut_u (.core_clk(core_clk), .rst(rst),
      .instr_valid(vld), .instr_word(word), .instr_addr(addr),
      .instr_ready(rdy), .negative_flag(st[5]), .carry_flag(st[4]),
      .bank_select_reg(st[3:0]), .pc_load(pc_load), .pc_target(pc_target),
      .flush(flush), .done(done), .unknown_op(unk), .mem_wr_en(wen),
      .mem_wr_addr(wa), .mem_wr_data(wd));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(negedge core_clk) begin
      if (pc_load === 1'b1) tks = 1'b1;
      if (unk === 1'b1) chk(32'h4, q.pop_front());
      if (done === 1'b1) begin
         obs = wen ? {20'h3, wa} : tks ? {11'h1, pc_target} : 32'h2;
         tks = 1'b0;
         chk(obs, q.pop_front());
      end
   end
   initial begin
      logic [15:0] w;
      logic [20:0] a, t;
      logic [5:0] s;
      repeat (6) @(posedge core_clk);
      @(negedge core_clk) rst = 1'b0;
      for (int i = 0; i < 60; i++) begin
         seed ^= seed << 13;
         seed ^= seed >> 17;
         seed ^= seed << 5;
         s = seed[5:0];
         a = {seed[31:12], 1'b0};
         w = seed[7] ? {BIT_CLEAR_NIBBLE, seed[27:16]} : {seed[6] ?
            BRANCH_NEG_BYTE : BRANCH_NO_CARRY_BYTE, seed[15:8]};
         // offset extremes first
         if (i < 2) w = {BRANCH_NEG_BYTE, i ? 8'h7F : 8'h80};
         if (i < 2) s[5] = 1'b1;
         t = a + PC_STEP + {{12{w[7]}}, w[7:0], 1'b0};
         if (w[15:12] == BIT_CLEAR_NIBBLE) q.push_back({20'h3, w[8] ?
            s[3:0] : w[7] ? ACCESS_HIGH_BANK : ACCESS_LOW_BANK, w[7:0]});
         else if (w[8] ? !s[4] : s[5]) q.push_back({11'h1, t});
         else q.push_back(32'h2);
         fm.send(w, a, s);
      end
      q.push_back(32'h4);
      fm.send(16'hE200, 21'h0, 6'h0);
      fm.stop;
      repeat (5) @(negedge core_clk);
      chk(q.size(), 32'h0);
      $display("random mix finished");
      results;
   end
   initial begin
      #10000;
      error_cnt++;
      results;
   end
endmodule

// ===== tb/fetch_model.sv
// fetch and status side: offers one word with flags and bank select
// changes at the falling edge, holds until taken at a rising edge
`timescale 1ns/1ps
module fetch_model (
   input wire logic clk,
   input wire logic rdy,
   output logic vld = 1'b0,
   output logic [15:0] word = 16'h0,
   output logic [20:0] addr = 21'h0,
   output logic [5:0] st = 6'h0
);
   logic tk;
   task automatic send(input logic [15:0] w, input logic [20:0] a,
      input logic [5:0] s);
      @(negedge clk);
      vld = 1'b1;
      word = w;
      addr = a;
      st = s;
      do begin
         #1 tk = rdy;
         @(posedge clk);
      end while (!tk);
   endtask
   // released lines show inverted junk
   task automatic stop;
      @(negedge clk);
      vld = 1'b0;
      word = ~word;
      addr = ~addr;
   endtask
endmodule
